// file: logic/tcpac_attach_ctrl.sv
module tcpac_attach_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input tcpac_pkg::tcpac_pins_s attachPins,
  output tcpac_pkg::tcpac_phy_s phyEn,
  output logic [1:0] padPullDownEn,
  input wire logic hostConnected,
  input wire logic hostSuperSpeed,
  output logic [1:0] hostSpeedOut,
  output logic [1:0] hostSpeedOe,
  input wire logic usb2Suspended,
  output logic suspendStateOut,
  input wire logic bridgeModeSel,
  input wire logic slaveClkLow,
  input wire logic slaveDatLow,
  input wire logic bridgeClkLow,
  input wire logic bridgeDatLow,
  input wire logic mgmtSerialClkIn,
  input wire logic mgmtSerialDatIn,
  output logic mgmtSerialClkOut,
  output logic mgmtSerialClkOe,
  output logic mgmtSerialDatOut,
  output logic mgmtSerialDatOe,
  output logic serialClkSync,
  output logic serialDatSync
);
  import tcpac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  logic [PINS_W-1:0] syncVec;
  tcpac_pins_s syncPins;
  logic modeTwo;
  logic polLow;
  logic [NUM_ATTACH-1:0] attachEff;
  logic [NUM_MUX_PORTS-1:0] orientEff;
  logic [NUM_MUX_PORTS-1:0] muxAEff;
  logic [NUM_MUX_PORTS-1:0] muxBEff;
  tcpac_phy_s phy_q;
  tcpac_phy_s phy_d;
  logic [1:0] speedOut_q;
  logic [1:0] speedOe_q;
  logic suspend_q;

  // returns {phy B enable, phy A enable} for one muxed port
  function automatic logic [1:0] portDecode(
    input logic mode2,
    input logic attach,
    input logic orient,
    input logic muxA,
    input logic muxB
  );
    logic [1:0] en;
    if (mode2) begin
      en = {muxB, muxA};
    end else begin
      en = {attach & orient, attach & ~orient};
    end
    return en;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pins arrive from an external controller with no clock relation

  tcpac_sync #(.W(PINS_W)) u_attach_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(attachPins),
    .syncOut(syncVec)
  );

  assign syncPins = syncVec;
  assign modeTwo = syncPins.ctrlModeSel;
  assign polLow = ~syncPins.attachPolaritySel;

  // one xor turns every attach-type input into an active-high level
  always_comb begin
    attachEff = syncPins.attachIn ^ {NUM_ATTACH{syncPins.attachPolaritySel}};
    orientEff = syncPins.orientationSelIn ^ {NUM_MUX_PORTS{syncPins.attachPolaritySel}};
    muxAEff = syncPins.orientAAttachIn ^ {NUM_MUX_PORTS{syncPins.attachPolaritySel}};
    muxBEff = syncPins.orientBAttachIn ^ {NUM_MUX_PORTS{syncPins.attachPolaritySel}};
  end

  // pads carry fixed pull-downs so floating selects read as mode 1, active high
  assign padPullDownEn = PULL_DOWN_ON;

  //////////////////////////////////////////////////////////////////////////////
  // phy power decisions

  always_comb begin
    phy_d = PHY_RESET;
    // the lone attach phy has no orientation pair, so it follows its attach in both modes
    phy_d.singlePhyEn = attachEff[0];
    for (int p = 0; p < NUM_MUX_PORTS; p++) begin
      {phy_d.phyBEn[p], phy_d.phyAEn[p]} = portDecode(modeTwo, attachEff[p+1],
        orientEff[p], muxAEff[p], muxBEff[p]);
    end
  end

  // registered so that phy power never sees a decode glitch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phy_q <= PHY_RESET;
    end else begin
      phy_q <= phy_d;
    end
  end

  assign phyEn = phy_q;

  //////////////////////////////////////////////////////////////////////////////
  // upstream speed indicator

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speedOut_q <= HOST_SPEED_LEGACY;
      speedOe_q <= HOST_SPEED_OE_OFF;
    end else begin
      speedOut_q <= hostSuperSpeed ? HOST_SPEED_SS : HOST_SPEED_LEGACY;
      speedOe_q <= hostConnected ? HOST_SPEED_OE_ON : HOST_SPEED_OE_OFF;
    end
  end

  assign hostSpeedOut = speedOut_q;
  assign hostSpeedOe = speedOe_q;

  //////////////////////////////////////////////////////////////////////////////
  // suspend indicator, a plain level usable as a wakeup sideband

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      suspend_q <= 1'h0;
    end else begin
      suspend_q <= usb2Suspended;
    end
  end

  assign suspendStateOut = suspend_q;

  //////////////////////////////////////////////////////////////////////////////
  // two-wire management pins

  tcpac_mgmt_pins u_mgmt_pins (
    .clk(clk),
    .reset_n(reset_n),
    .bridgeModeSel(bridgeModeSel),
    .slaveClkLow(slaveClkLow),
    .slaveDatLow(slaveDatLow),
    .bridgeClkLow(bridgeClkLow),
    .bridgeDatLow(bridgeDatLow),
    .mgmtSerialClkIn(mgmtSerialClkIn),
    .mgmtSerialDatIn(mgmtSerialDatIn),
    .mgmtSerialClkOut(mgmtSerialClkOut),
    .mgmtSerialClkOe(mgmtSerialClkOe),
    .mgmtSerialDatOut(mgmtSerialDatOut),
    .mgmtSerialDatOe(mgmtSerialDatOe),
    .serialClkSync(serialClkSync),
    .serialDatSync(serialDatSync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!reset_n);

  for (genvar i = 0; i < NUM_MUX_PORTS; i++) begin : g_chk
    mode2OrientB_a: assert property (
      modeTwo && muxBEff[i] |=> phyEn.phyBEn[i])
      else $error("orientation B phy off despite mode 2 attach");

    mode2OrientA_a: assert property (
      modeTwo && muxAEff[i] |=> phyEn.phyAEn[i])
      else $error("orientation A phy off despite mode 2 attach");

    mode2Ignore_a: assert property (
      modeTwo && !muxAEff[i] && !muxBEff[i] |=> !phyEn.phyAEn[i] && !phyEn.phyBEn[i])
      else $error("mode 2 phy on without per-orientation attach");

    noAttachOff_a: assert property (
      !modeTwo && !attachEff[i+1] |=> !phyEn.phyAEn[i] && !phyEn.phyBEn[i])
      else $error("phy powered with no attach in mode 1");

    mode1Follow_a: assert property (
      !modeTwo |=> (phyEn.phyAEn[i] || phyEn.phyBEn[i]) == $past(attachEff[i+1]))
      else $error("mode 1 phy power not tied to attach input");

    highPolOrient_a: assert property (
      polLow && !modeTwo && syncPins.attachIn[i+1] && syncPins.orientationSelIn[i]
      |=> phyEn.phyBEn[i] && !phyEn.phyAEn[i])
      else $error("orientation 1 did not select phy B");

    activeHigh_a: assert property (
      polLow && !modeTwo && syncPins.attachIn[i+1] && !syncPins.orientationSelIn[i]
      |=> phyEn.phyAEn[i] && !phyEn.phyBEn[i])
      else $error("active-high attach with orientation 0 did not select phy A");

    activeLow_a: assert property (
      !polLow && !modeTwo && !syncPins.attachIn[i+1] && !syncPins.orientationSelIn[i]
      |=> phyEn.phyBEn[i] && !phyEn.phyAEn[i])
      else $error("inverted polarity not applied to attach and orientation");

    oneSide_a: assert property (
      !modeTwo |=> !(phyEn.phyAEn[i] && phyEn.phyBEn[i]))
      else $error("both orientation phys on in mode 1");

    // raw pad checks, all but muxIgnored_a: effective levels share the xor under test, pads do not
    invOrientA_a: assert property (
      !polLow && !modeTwo && !syncPins.attachIn[i+1] && syncPins.orientationSelIn[i]
      |=> phyEn.phyAEn[i] && !phyEn.phyBEn[i])
      else $error("inverted orientation 1 did not select phy A");

    invMode2B_a: assert property (
      !polLow && modeTwo && !syncPins.orientBAttachIn[i] |=> phyEn.phyBEn[i])
      else $error("low-active orientation B attach left phy B off");

    invMode2A_a: assert property (
      !polLow && modeTwo && !syncPins.orientAAttachIn[i] |=> phyEn.phyAEn[i])
      else $error("low-active orientation A attach left phy A off");

    highMode2B_a: assert property (
      polLow && modeTwo && syncPins.orientBAttachIn[i] |=> phyEn.phyBEn[i])
      else $error("high-active orientation B attach left phy B off");

    muxIgnored_a: assert property (
      !modeTwo && !attachEff[i+1] && (muxAEff[i] || muxBEff[i])
      |=> !phyEn.phyAEn[i] && !phyEn.phyBEn[i])
      else $error("per-orientation attach powered a phy in mode 1");
  end

  singleAttach_a: assert property (
    ##1 (phyEn.singlePhyEn == $past(attachEff[0])))
    else $error("single phy power does not follow its attach");

  singleHigh_a: assert property (
    polLow && syncPins.attachIn[0] |=> phyEn.singlePhyEn)
    else $error("active-high attach left the single phy off");

  singleInv_a: assert property (
    !polLow && !syncPins.attachIn[0] |=> phyEn.singlePhyEn)
    else $error("active-low attach left the single phy off");

  singleOff_a: assert property (
    polLow && !syncPins.attachIn[0] |=> !phyEn.singlePhyEn)
    else $error("single phy powered with no attach");

  // polarity must sit low through the window too, else its own sync lag delays the phy
  pinToPhy_a: assert property (
    $rose(attachPins.attachIn[0]) && !attachPins.attachPolaritySel
    ##1 (attachPins.attachIn[0] && !attachPins.attachPolaritySel) [*4]
    |-> ##[1:3] phyEn.singlePhyEn)
    else $error("stable attach pin never reached the phy enable");

  speedFloat_a: assert property (
    !hostConnected |=> hostSpeedOe == HOST_SPEED_OE_OFF)
    else $error("speed indicator driven with no host");

  speedLevel_a: assert property (
    hostConnected |=> hostSpeedOe == HOST_SPEED_OE_ON
      && hostSpeedOut == $past(hostSuperSpeed ? HOST_SPEED_SS : HOST_SPEED_LEGACY))
    else $error("speed indicator level wrong for host speed");

  speedSuper_a: assert property (
    hostConnected && hostSuperSpeed |=> hostSpeedOut == HOST_SPEED_SS)
    else $error("speed indicator not low for a superspeed host");

  speedLegacy_a: assert property (
    hostConnected && !hostSuperSpeed |=> hostSpeedOut == HOST_SPEED_LEGACY)
    else $error("speed indicator not high for a legacy host");

  suspendFollow_a: assert property (
    ##1 (suspendStateOut == $past(usb2Suspended)))
    else $error("suspend indicator does not follow suspend state");

  suspendSet_a: assert property (
    usb2Suspended |=> suspendStateOut)
    else $error("suspend indicator low while suspended");

  suspendClr_a: assert property (
    !usb2Suspended |=> !suspendStateOut)
    else $error("suspend indicator high while not suspended");

  pullDown_a: assert property (
    padPullDownEn == PULL_DOWN_ON)
    else $error("select pull-downs not enabled");

  mode1B_c: cover property (!modeTwo ##1 phyEn.phyBEn[0]);
  mode2Both_c: cover property (modeTwo ##1 phyEn.phyAEn[1] && phyEn.phyBEn[1]);
  invPol_c: cover property (!polLow && !modeTwo ##1 phyEn.phyAEn[0]);
  superSpeed_c: cover property (hostSpeedOe == HOST_SPEED_OE_ON && hostSpeedOut == HOST_SPEED_SS);
  suspend_c: cover property (usb2Suspended ##1 suspendStateOut);

endmodule

// file: logic/tcpac_mgmt_pins.sv
module tcpac_mgmt_pins (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bridgeModeSel,
  input wire logic slaveClkLow,
  input wire logic slaveDatLow,
  input wire logic bridgeClkLow,
  input wire logic bridgeDatLow,
  input wire logic mgmtSerialClkIn,
  input wire logic mgmtSerialDatIn,
  output logic mgmtSerialClkOut,
  output logic mgmtSerialClkOe,
  output logic mgmtSerialDatOut,
  output logic mgmtSerialDatOe,
  output logic serialClkSync,
  output logic serialDatSync
);
  import tcpac_pkg::*;

  logic clkOe_q;
  logic datOe_q;
  logic [1:0] pinSync;

  tcpac_sync #(.W(2)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({mgmtSerialClkIn, mgmtSerialDatIn}),
    .syncOut(pinSync)
  );

  // slave only stretches the clock; bridge owns it as master
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkOe_q <= 1'h0;
      datOe_q <= 1'h0;
    end else begin
      clkOe_q <= bridgeModeSel ? bridgeClkLow : slaveClkLow;
      datOe_q <= bridgeModeSel ? bridgeDatLow : slaveDatLow;
    end
  end

  assign mgmtSerialClkOut = OD_LOW;
  assign mgmtSerialDatOut = OD_LOW;
  assign mgmtSerialClkOe = clkOe_q;
  assign mgmtSerialDatOe = datOe_q;
  assign serialClkSync = pinSync[1];
  assign serialDatSync = pinSync[0];

  roleSteer_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ##1 (mgmtSerialClkOe == $past(bridgeModeSel ? bridgeClkLow : slaveClkLow)))
    else $error("serial clock drive not from the selected role");

endmodule

// file: logic/tcpac_pkg.sv
package tcpac_pkg;

  // port counts: one attach-only phy plus two orientation-muxed ports
  localparam int NUM_ATTACH = 3;
  localparam int NUM_MUX_PORTS = 2;
  localparam int SYNC_STAGES = 3;

  // attach, orientation and mode pins as they arrive at the pads
  typedef struct packed {
    logic ctrlModeSel;
    logic attachPolaritySel;
    logic [NUM_ATTACH-1:0] attachIn;
    logic [NUM_MUX_PORTS-1:0] orientationSelIn;
    logic [NUM_MUX_PORTS-1:0] orientAAttachIn;
    logic [NUM_MUX_PORTS-1:0] orientBAttachIn;
  } tcpac_pins_s;

  localparam int PINS_W = $bits(tcpac_pins_s);

  // superspeed phy power enables
  typedef struct packed {
    logic singlePhyEn;
    logic [NUM_MUX_PORTS-1:0] phyAEn;
    logic [NUM_MUX_PORTS-1:0] phyBEn;
  } tcpac_phy_s;

  localparam tcpac_phy_s PHY_RESET = '{singlePhyEn: 1'h0, phyAEn: 2'h0, phyBEn: 2'h0};

  // upstream speed indicator levels, driven on both indicator pins
  localparam logic [1:0] HOST_SPEED_SS = 2'h0;
  localparam logic [1:0] HOST_SPEED_LEGACY = 2'h3;
  localparam logic [1:0] HOST_SPEED_OE_ON = 2'h3;
  localparam logic [1:0] HOST_SPEED_OE_OFF = 2'h0;

  // pad pull-downs on polarity and mode select: always enabled
  localparam logic [1:0] PULL_DOWN_ON = 2'h3;

  // open-drain pins only ever drive low
  localparam logic OD_LOW = 1'h0;

endpackage

// file: logic/tcpac_sync.sv
module tcpac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  import tcpac_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      meta_q <= asyncIn;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // a change counts only once two late stages agree; filters one-cycle glitches
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        out_q[b] <= 1'h0;
      end else if (stage2_q[b] == stage3_q[b]) begin
        out_q[b] <= stage3_q[b];
      end
    end

    syncAgree_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      $changed(out_q[b]) |-> ($past(stage2_q[b]) == $past(stage3_q[b])))
      else $error("synchronised bit changed while stages disagreed");
  end

  assign syncOut = out_q;

endmodule

// file: verification/tcpac_conn_model.sv
module tcpac_conn_model (
  input wire logic modeSel,
  input wire logic polSel,
  input wire logic [2:0] attach,
  input wire logic [1:0] orient,
  input wire logic [1:0] altA,
  input wire logic [1:0] altB,
  output tcpac_pkg::tcpac_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  import tcpac_pkg::*;

  // logical attach state turned into pad levels; an open select pad reads low
  always_comb begin
    pins.ctrlModeSel = modeSel;
    pins.attachPolaritySel = polSel;
    pins.attachIn = attach ^ {3{polSel}};
    pins.orientationSelIn = orient ^ {2{polSel}};
    pins.orientAAttachIn = altA ^ {2{polSel}};
    pins.orientBAttachIn = altB ^ {2{polSel}};
  end
endmodule

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tcpac_pkg::*;

  logic clk, reset_n, modeSel, polSel;
  logic [2:0] attach;
  logic [1:0] orient, altA, altB, hostSpeedOut, hostSpeedOe, padPullDownEn;
  logic hostConnected, hostSuperSpeed, usb2Suspended, suspendStateOut, bridgeModeSel;
  logic slaveClkLow, slaveDatLow, bridgeClkLow, bridgeDatLow, extClkLow, extDatLow;
  logic clkOut, clkOe, datOut, datOe, serialClkSync, serialDatSync;
  tcpac_pins_s pins;
  tcpac_phy_s phyEn;
  int n_errors, cmp_count;
  logic [8:0] vec [4] = '{9'h000, 9'h1DF, 9'h169, 9'h0B6};

  tcpac_conn_model tcpac_conn_model_i (.modeSel(modeSel), .polSel(polSel), .attach(attach),
    .orient(orient), .altA(altA), .altB(altB), .pins(pins));

  tcpac_attach_ctrl tcpac_attach_ctrl_i (.clk(clk), .reset_n(reset_n), .attachPins(pins),
    .phyEn(phyEn), .padPullDownEn(padPullDownEn), .hostConnected(hostConnected),
    .hostSuperSpeed(hostSuperSpeed), .hostSpeedOut(hostSpeedOut), .hostSpeedOe(hostSpeedOe),
    .usb2Suspended(usb2Suspended), .suspendStateOut(suspendStateOut),
    .bridgeModeSel(bridgeModeSel), .slaveClkLow(slaveClkLow), .slaveDatLow(slaveDatLow),
    .bridgeClkLow(bridgeClkLow), .bridgeDatLow(bridgeDatLow),
    .mgmtSerialClkIn(~(clkOe | extClkLow)), .mgmtSerialDatIn(~(datOe | extDatLow)),
    .mgmtSerialClkOut(clkOut), .mgmtSerialClkOe(clkOe), .mgmtSerialDatOut(datOut),
    .mgmtSerialDatOe(datOe), .serialClkSync(serialClkSync), .serialDatSync(serialDatSync));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #(25*3000);
    n_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] exp;
    {reset_n, modeSel, polSel, attach, orient, altA, altB} = '0;
    {hostConnected, hostSuperSpeed, usb2Suspended, bridgeModeSel} = '0;
    {slaveClkLow, slaveDatLow, bridgeClkLow, bridgeDatLow, extClkLow, extDatLow} = '0;
    n_errors = 0;
    cmp_count = 0;
    idle(8);
    reset_n = 1'h1;
    idle(2);
    chk("pullDown", 5'h03, {3'h0, padPullDownEn});
    chk("phyIdle", 5'h00, phyEn);
    // every polarity and mode; the unused mode's pins carry asserted levels too
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 2; m++) begin
        for (int v = 0; v < 4; v++) begin
          polSel = p[0];
          modeSel = m[0];
          {attach, orient, altA, altB} = vec[v];
          idle(7);
          exp[4] = attach[0];
          exp[3:2] = m[0] ? altA : attach[2:1] & ~orient;
          exp[1:0] = m[0] ? altB : attach[2:1] & orient;
          chk("phyEn", exp, phyEn);
        end
      end
    end
    $display("test phy enables done");
    for (int i = 0; i < 3; i++) begin
      hostConnected = i < 2;
      hostSuperSpeed = i == 0;
      idle(2);
      chk("speedOe", i < 2 ? 5'h03 : 5'h00, {3'h0, hostSpeedOe});
      if (i < 2) begin
        chk("speedOut", i == 0 ? 5'h00 : 5'h03, {3'h0, hostSpeedOut});
      end
    end
    for (int i = 0; i < 3; i++) begin
      usb2Suspended = i[0];
      idle(2);
      chk("suspend", {4'h0, i[0]}, {4'h0, suspendStateOut});
    end
    $display("test indicators done");
    // each role's pull-low requests, with the other role's requests set as noise
    for (int i = 0; i < 32; i++) begin
      {bridgeModeSel, slaveClkLow, slaveDatLow, bridgeClkLow, bridgeDatLow} = i[4:0];
      idle(2);
      exp = i[4] ? {3'h0, i[1:0]} : {3'h0, i[3:2]};
      chk("serialOe", exp, {3'h0, clkOe, datOe});
      chk("serialOut", 5'h00, {3'h0, clkOut, datOut});
    end
    {slaveClkLow, slaveDatLow, bridgeClkLow, bridgeDatLow} = '0;
    for (int i = 0; i < 4; i++) begin
      {extClkLow, extDatLow} = i[1:0];
      idle(6);
      chk("serialSync", {3'h0, ~i[1:0]}, {3'h0, serialClkSync, serialDatSync});
    end
    $display("test serial pins done");
    end_sim();
  end
endmodule
